//--- src/pgs_pkg.sv
// Constants and types for the power-good status and select register bank
//
// Function
// - Third regulator output code held in bits 3:0, 0000 highest, 1111 lowest.
// - Third regulator code is ignored while that channel is a load switch.
// - Status bit 3 reads live bus-supply-in-range condition.
// - Status bit 2 reads live battery-above-weak comparison.
// - Status bit 1 mirrors live boost power-good; meaningful in standalone fixed mode.
// - Status bit 0 mirrors live first regulator power-good.
// - Select bit 3 routes bus status to power-good pin; factory reset value.
// - Select bit 2 routes battery status to power-good pin; resets to 0.
// - Select bit 1 routes boost good to pin, only in standalone mode; resets 0.
// - Select bit 0 routes first regulator good to pin, unless load switch.
// - Bits 7:4 of code, status and select registers are unused, read-only.
// - Config bit 2 makes third channel a load switch; resets to regulator.
// - Config bit 0 makes first channel a load switch; resets to regulator.
package pgs_pkg;

  // ---------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------
  localparam logic [6:0] PGS_DEV_ADDR     = 7'h2A; // Arbitrary bus address
  localparam logic [3:0] PGS_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] PGS_LAST_TX_BIT  = 4'h7;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PGS_CFG_ADDR    = 8'h33;
  localparam logic [7:0] PGS_VCODE_ADDR  = 8'h35;
  localparam logic [7:0] PGS_STATUS_ADDR = 8'h36;
  localparam logic [7:0] PGS_SELECT_ADDR = 8'h37;
  localparam logic [7:0] PGS_UNMAPPED_RD = 8'h00;

  // Field positions
  localparam int PGS_CFG_REG3_SWITCH_BIT = 2;
  localparam int PGS_CFG_REG1_SWITCH_BIT = 0;
  localparam int PGS_BUS_BIT             = 3;
  localparam int PGS_BAT_BIT             = 2;
  localparam int PGS_BOOST_BIT           = 1;
  localparam int PGS_REG1_BIT            = 0;

  // Reset values; factory bits have arbitrary defaults
  localparam logic [3:0] PGS_VCODE_RST  = 4'h6;
  localparam logic [3:0] PGS_SELECT_RST = 4'h9;
  localparam logic       PGS_SWITCH_RST = 1'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic bus_voltage_in_range;
    logic battery_above_weak;
    logic boost_power_good;
    logic regulator1_power_good;
  } pgs_status_t;

  typedef enum logic [6:0] {
    PGS_IDLE  = 7'h01,
    PGS_ADDR  = 7'h02,
    PGS_AACK  = 7'h04,
    PGS_RX    = 7'h08,
    PGS_RACK  = 7'h10,
    PGS_TX    = 7'h20,
    PGS_TACK  = 7'h40
  } pgs_fsm_t;

  typedef struct packed {
    pgs_fsm_t   fsm;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic       rd;
    logic       ptr_phase;
    logic       nack;
    logic [7:0] ptr;
    logic       sda_drive;
    logic       reg3_switch;
    logic       reg1_switch;
    logic [3:0] vcode;
    logic [3:0] select;
    logic       pin_good;
  } pgs_state_t;

endpackage : pgs_pkg

//--- src/pgs_src_gate.sv
// One source term of the power-good pin combine
`timescale 1ns/10ps
module pgs_src_gate (
  input  wire logic select_i,
  input  wire logic effective_i,
  input  wire logic good_i,
  output logic      pass_o
);
  // Unselected or ineffective sources never pull the pin bad
  assign pass_o = ~(select_i & effective_i) | good_i;
endmodule : pgs_src_gate

//--- src/pgs_top.sv
// Power-good status and select register bank behind a two-wire serial port
`timescale 1ns/10ps
module pgs_top
  import pgs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire pgs_status_t status_i,
  input  wire logic        boost_standalone_i,
  output logic [3:0]       regulator3_voltage_code_o,
  output logic             regulator3_code_active_o,
  output logic             regulator3_switch_select_o,
  output logic             regulator1_switch_select_o,
  output logic             power_good_pin_o
);

  pgs_state_t s_reg;
  pgs_state_t s_next;
  logic [3:0] status_bits;
  logic [3:0] effective;
  logic [3:0] pass;
  logic [7:0] rd_data;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  // ---------------------------------------------------------------
  // Live status and pin combine
  // ---------------------------------------------------------------
  assign status_bits = status_i;

  assign effective[PGS_BUS_BIT]   = 1'b1;
  assign effective[PGS_BAT_BIT]   = 1'b1;
  assign effective[PGS_BOOST_BIT] = boost_standalone_i;
  assign effective[PGS_REG1_BIT]  = ~s_reg.reg1_switch;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_src
      pgs_src_gate u_gate (
        .select_i    (s_reg.select[g]),
        .effective_i (effective[g]),
        .good_i      (status_bits[g]),
        .pass_o      (pass[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (s_reg.ptr)
      PGS_CFG_ADDR: begin
        rd_data = 8'h00;
        rd_data[PGS_CFG_REG3_SWITCH_BIT] = s_reg.reg3_switch;
        rd_data[PGS_CFG_REG1_SWITCH_BIT] = s_reg.reg1_switch;
      end
      PGS_VCODE_ADDR:  rd_data = {4'h0, s_reg.vcode};
      PGS_STATUS_ADDR: rd_data = {4'h0, status_bits};
      PGS_SELECT_ADDR: rd_data = {4'h0, s_reg.select};
      default:         rd_data = PGS_UNMAPPED_RD;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus condition detect
  // ---------------------------------------------------------------
  assign scl_rise   = scl_i & ~s_reg.scl_q;
  assign scl_fall   = ~scl_i & s_reg.scl_q;
  assign start_cond = scl_i & s_reg.scl_q & s_reg.sda_q & ~sda_i;
  assign stop_cond  = scl_i & s_reg.scl_q & ~s_reg.sda_q & sda_i;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.scl_q    = scl_i;
    s_next.sda_q    = sda_i;
    s_next.pin_good = &pass;

    if (stop_cond) begin
      s_next.fsm       = PGS_IDLE;
      s_next.sda_drive = 1'b0;
    end else if (start_cond) begin
      s_next.fsm       = PGS_ADDR;
      s_next.cnt       = 4'h0;
      s_next.sda_drive = 1'b0;
    end else begin
      case (s_reg.fsm)
        PGS_IDLE: begin
          s_next.sda_drive = 1'b0;
        end
        PGS_ADDR: begin
          if (scl_rise) begin
            s_next.shift = {s_reg.shift[6:0], sda_i};
            s_next.cnt   = s_reg.cnt + 4'h1;
          end else if (scl_fall && s_reg.cnt == PGS_BITS_PER_BYTE) begin
            if (s_reg.shift[7:1] == PGS_DEV_ADDR) begin
              s_next.fsm       = PGS_AACK;
              s_next.rd        = s_reg.shift[0];
              s_next.ptr_phase = ~s_reg.shift[0];
              s_next.sda_drive = 1'b1;
            end else begin
              s_next.fsm = PGS_IDLE;
            end
          end
        end
        PGS_AACK: begin
          if (scl_fall) begin
            s_next.cnt = 4'h0;
            if (s_reg.rd) begin
              s_next.fsm       = PGS_TX;
              s_next.shift     = rd_data;
              s_next.sda_drive = ~rd_data[7];
              s_next.ptr       = s_reg.ptr + 8'h01;
            end else begin
              s_next.fsm       = PGS_RX;
              s_next.sda_drive = 1'b0;
            end
          end
        end
        PGS_RX: begin
          if (scl_rise) begin
            s_next.shift = {s_reg.shift[6:0], sda_i};
            s_next.cnt   = s_reg.cnt + 4'h1;
          end else if (scl_fall && s_reg.cnt == PGS_BITS_PER_BYTE) begin
            s_next.fsm       = PGS_RACK;
            s_next.sda_drive = 1'b1;
            if (s_reg.ptr_phase) begin
              s_next.ptr       = s_reg.shift;
              s_next.ptr_phase = 1'b0;
            end else begin
              s_next.ptr = s_reg.ptr + 8'h01;
              case (s_reg.ptr)
                PGS_CFG_ADDR: begin
                  s_next.reg3_switch = s_reg.shift[PGS_CFG_REG3_SWITCH_BIT];
                  s_next.reg1_switch = s_reg.shift[PGS_CFG_REG1_SWITCH_BIT];
                end
                PGS_VCODE_ADDR:  s_next.vcode  = s_reg.shift[3:0];
                PGS_SELECT_ADDR: s_next.select = s_reg.shift[3:0];
                default: begin
                  // Status and unmapped writes are dropped
                  s_next.ptr = s_reg.ptr + 8'h01;
                end
              endcase
            end
          end
        end
        PGS_RACK: begin
          if (scl_fall) begin
            s_next.fsm       = PGS_RX;
            s_next.cnt       = 4'h0;
            s_next.sda_drive = 1'b0;
          end
        end
        PGS_TX: begin
          if (scl_fall) begin
            if (s_reg.cnt == PGS_LAST_TX_BIT) begin
              s_next.fsm       = PGS_TACK;
              s_next.sda_drive = 1'b0;
            end else begin
              s_next.shift     = {s_reg.shift[6:0], 1'b0};
              s_next.sda_drive = ~s_reg.shift[6];
              s_next.cnt       = s_reg.cnt + 4'h1;
            end
          end
        end
        PGS_TACK: begin
          if (scl_rise) begin
            s_next.nack = sda_i;
          end else if (scl_fall) begin
            if (s_reg.nack) begin
              s_next.fsm = PGS_IDLE;
            end else begin
              s_next.fsm       = PGS_TX;
              s_next.cnt       = 4'h0;
              s_next.shift     = rd_data;
              s_next.sda_drive = ~rd_data[7];
              s_next.ptr       = s_reg.ptr + 8'h01;
            end
          end
        end
        default: begin
          s_next.fsm       = PGS_IDLE;
          s_next.sda_drive = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg.fsm         <= PGS_IDLE;
      s_reg.scl_q       <= 1'b1;
      s_reg.sda_q       <= 1'b1;
      s_reg.shift       <= 8'h00;
      s_reg.cnt         <= 4'h0;
      s_reg.rd          <= 1'b0;
      s_reg.ptr_phase   <= 1'b0;
      s_reg.nack        <= 1'b0;
      s_reg.ptr         <= 8'h00;
      s_reg.sda_drive   <= 1'b0;
      s_reg.reg3_switch <= PGS_SWITCH_RST;
      s_reg.reg1_switch <= PGS_SWITCH_RST;
      s_reg.vcode       <= PGS_VCODE_RST;
      s_reg.select      <= PGS_SELECT_RST;
      s_reg.pin_good    <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sda_o                      = 1'b0;
  assign sda_oe_o                   = s_reg.sda_drive;
  assign regulator3_voltage_code_o  = s_reg.vcode;
  assign regulator3_code_active_o   = ~s_reg.reg3_switch;
  assign regulator3_switch_select_o = s_reg.reg3_switch;
  assign regulator1_switch_select_o = s_reg.reg1_switch;
  assign power_good_pin_o           = s_reg.pin_good;

endmodule : pgs_top

//--- test/pgs_chk.sv
// Port assertions for the power-good register bank
`timescale 1ns/10ps
module pgs_chk
  import pgs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire pgs_status_t status_i,
  input wire logic        boost_standalone_i,
  input wire logic [3:0]  regulator3_voltage_code_o,
  input wire logic        regulator3_code_active_o,
  input wire logic        regulator3_switch_select_o,
  input wire logic        regulator1_switch_select_o,
  input wire logic        power_good_pin_o
);
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  reset_code_a: assert property ($rose(reset_n_i) |-> regulator3_voltage_code_o == PGS_VCODE_RST)
    else $error("code reset value wrong");
  code_ack_a: assert property ($changed(regulator3_voltage_code_o) |-> ##[0:2] sda_oe_o)
    else $error("code changed outside a write");
  switch_ack_a: assert property ($changed(regulator3_switch_select_o) |-> ##[0:2] sda_oe_o)
    else $error("switch changed outside a write");
  code_active_a: assert property (regulator3_code_active_o == !regulator3_switch_select_o)
    else $error("code active flag wrong");
  all_good_a: assert property (&status_i |=> power_good_pin_o)
    else $error("pin low with all sources good");
  reg1_ignore_a:
    assert property (regulator1_switch_select_o && status_i[3:1] == 3'h7 |=> power_good_pin_o)
    else $error("switched regulator one still gates pin");
  boost_ignore_a:
    assert property (!boost_standalone_i && status_i[3] && status_i[2] && status_i[0] |=> power_good_pin_o)
    else $error("boost gates pin outside standalone mode");
  pin_fall_a: assert property ($fell(power_good_pin_o) |-> $past(status_i) != 4'hF)
    else $error("pin fell with all sources good");
  pin_low_c: cover property ($fell(power_good_pin_o));
  code_set_c: cover property ($changed(regulator3_voltage_code_o));
  switch_set_c: cover property ($rose(regulator1_switch_select_o));
endmodule : pgs_chk
bind pgs_top pgs_chk chk (.clk_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .status_i, .boost_standalone_i,
  .regulator3_voltage_code_o, .regulator3_code_active_o, .regulator3_switch_select_o, .regulator1_switch_select_o,
  .power_good_pin_o);

//--- test/pgs_host.sv
// Two-wire host model driving the register port
`timescale 1ns/10ps
module pgs_host
  import pgs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // ----------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------
  initial begin
    scl_o = 1'h1;
    sda_pull_o = 1'h0;
  end
  task automatic half();
    repeat (3) @(posedge clk_i);
  endtask : half
  // Data changes while clock low, sampled at end of high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o <= !b;
    half();
    scl_o <= 1'h1;
    half();
    r = sda_i;
    scl_o <= 1'h0;
  endtask : bit_io
  task automatic start();
    sda_pull_o <= 1'h0;
    half();
    scl_o <= 1'h1;
    half();
    sda_pull_o <= 1'h1;
    half();
    scl_o <= 1'h0;
  endtask : start
  task automatic stop();
    sda_pull_o <= 1'h1;
    half();
    scl_o <= 1'h1;
    half();
    sda_pull_o <= 1'h0;
    half();
  endtask : stop
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'h1, ack);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nk);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({PGS_DEV_ADDR, 1'h0}, q, n0);
    xfer(a, q, n1);
    xfer(d, q, n2);
    stop();
    nk = n0 | n1 | n2;
  endtask : wr
  // Fresh bus read each call, nothing cached
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic nk);
    logic [7:0] x;
    logic n0, n1, n2, n3;
    start();
    xfer({PGS_DEV_ADDR, 1'h0}, x, n0);
    xfer(a, x, n1);
    start();
    xfer({PGS_DEV_ADDR, 1'h1}, x, n2);
    xfer(8'hFF, q, n3);
    stop();
    nk = n0 | n1 | n2;
  endtask : rd
endmodule : pgs_host

//--- test/power_good_status_select_bench.sv
// Self-checking bench for the power-good register bank
`timescale 1ns/10ps
module power_good_status_select_bench
  import pgs_pkg::*;
;
  // ----------------------------------------------------------
  // Harness
  // ----------------------------------------------------------
  logic        clk_i = 1'h0;
  logic        reset_n_i = 1'h0;
  logic        boost_i = 1'h0;
  pgs_status_t status_i = 4'hF;
  logic        scl, pull, sda_o, sda_oe_o, act_o, sw3_o, sw1_o, pin_o, nk;
  logic [3:0]  code_o;
  logic [7:0]  q;
  int          failures = 0;
  int          tests_run = 0;
  wire         sda = !(pull | sda_oe_o);
  always #5 clk_i = ~clk_i;
  pgs_host host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  pgs_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .status_i(status_i), .boost_standalone_i(boost_i), .regulator3_voltage_code_o(code_o),
    .regulator3_code_active_o(act_o), .regulator3_switch_select_o(sw3_o), .regulator1_switch_select_o(sw1_o),
    .power_good_pin_o(pin_o));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, nk);
    chk("ack", 8'h00, {7'h00, nk});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q, nk);
    chk("ack", 8'h00, {7'h00, nk});
    chk("read", e, q);
    chk("data pin", 8'h00, {7'h00, sda_o});
  endtask : rd
  function automatic logic good(input logic [3:0] s, input logic [3:0] sel, input logic b, input logic r1);
    logic [3:0] eff;
    eff = {2'h3, b, !r1};
    return &(~(sel & eff) | s);
  endfunction : good
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    // Tests need about 11000 cycles
    repeat (30000) @(posedge clk_i);
    failures++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rd(PGS_VCODE_ADDR, {4'h0, PGS_VCODE_RST});
    rd(PGS_SELECT_ADDR, {4'h0, PGS_SELECT_RST[3], 2'h0, PGS_SELECT_RST[0]});
    rd(PGS_CFG_ADDR, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 16; i += 5) begin
      status_i <= i[3:0];
      wr(PGS_STATUS_ADDR, 8'hFF);
      rd(PGS_STATUS_ADDR, {4'h0, i[3:0]});
    end
    $display("test status done");
    wr(PGS_VCODE_ADDR, 8'hFF);
    rd(PGS_VCODE_ADDR, 8'h0F);
    chk("code", 8'h0F, {4'h0, code_o});
    wr(PGS_CFG_ADDR, 8'hFF);
    rd(PGS_CFG_ADDR, 8'h05);
    chk("active", 8'h00, {7'h00, act_o});
    chk("switch3", 8'h01, {7'h00, sw3_o});
    chk("switch1", 8'h01, {7'h00, sw1_o});
    wr(8'h40, 8'h5A);
    rd(8'h40, 8'h00);
    $display("test config done");
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 16; s++) begin
        wr(PGS_SELECT_ADDR, s[7:0]);
        for (int t = 0; t < 16; t++) begin
          status_i <= t[3:0];
          repeat (2) @(posedge clk_i);
          chk("pin", {7'h00, good(t[3:0], s[3:0], boost_i, c == 0)}, {7'h00, pin_o});
        end
      end
      wr(PGS_CFG_ADDR, 8'h00);
      boost_i <= 1'h1;
    end
    chk("active", 8'h01, {7'h00, act_o});
    chk("switch3", 8'h00, {7'h00, sw3_o});
    chk("switch1", 8'h00, {7'h00, sw1_o});
    $display("test pin done");
    final_report();
  end
endmodule : power_good_status_select_bench
